// ==== sim/cos_status_regs_tb_top.sv ====
`timescale 1ns/1ns
module cos_status_regs_tb_top
   import cos_pkg::*;
;
   logic               aclk = 1'b0;
   logic               aresetn;
   logic [ADDR_W-1:0]  awaddr;
   logic               awvalid;
   logic               awready;
   logic [DATA_W-1:0]  wdata;
   logic               wvalid;
   logic               wready;
   logic [1:0]         bresp;
   logic               bvalid;
   logic               bready;
   logic [ADDR_W-1:0]  araddr;
   logic               arvalid;
   logic               arready;
   logic [DATA_W-1:0]  rdata;
   logic [1:0]         rresp;
   logic               rvalid;
   logic               rready;
   cos_mis_req_t       mis_req;
   cos_mh_evt_t        mh_evt;
   logic [NUM_OBJ-1:0] nd_flags;
   logic [NUM_OBJ-1:0] ip_flags;
   logic [NUM_OBJ-1:0] ov_flags;
   logic [5:0]         pending_id;
   logic               can_clk_en;
   logic               irq;
   int                 err_total;
   int                 checks_done;
   logic [31:0]        rd;
   logic [1:0]         rsp;
   int                 cnt;
   logic [3:0]         divs [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hf};

   cos_status_regs DUT
   (
      .aclk                   (aclk),
      .aresetn                (aresetn),
      .s_axi_awaddr           (awaddr),
      .s_axi_awvalid          (awvalid),
      .s_axi_awready          (awready),
      .s_axi_wdata            (wdata),
      .s_axi_wstrb            (4'hf),
      .s_axi_wvalid           (wvalid),
      .s_axi_wready           (wready),
      .s_axi_bresp            (bresp),
      .s_axi_bvalid           (bvalid),
      .s_axi_bready           (bready),
      .s_axi_araddr           (araddr),
      .s_axi_arvalid          (arvalid),
      .s_axi_arready          (arready),
      .s_axi_rdata            (rdata),
      .s_axi_rresp            (rresp),
      .s_axi_rvalid           (rvalid),
      .s_axi_rready           (rready),
      .mis_req                (mis_req),
      .mh_evt                 (mh_evt),
      .new_data_flag          (nd_flags),
      .interrupt_pending_flag (ip_flags),
      .object_valid_flag      (ov_flags),
      .pending_id             (pending_id),
      .can_clk_en             (can_clk_en),
      .irq                    (irq)
   );

   always #4 aclk = ~aclk;

   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // Ready sampled mid-cycle, acted on at the next rising edge
   task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ah;
      logic wh;
      logic bh;
      @(posedge aclk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      bh = 1'b0;
      while (!bh)
      begin
         @(negedge aclk);
         ah = awvalid & awready;
         wh = wvalid & wready;
         bh = bvalid;
         r  = bresp;
         @(posedge aclk);
         if (ah)
            awvalid <= 1'b0;
         if (wh)
            wvalid <= 1'b0;
         if (bh)
            bready <= 1'b0;
      end
   endtask

   task automatic rdr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ah;
      logic rh;
      @(posedge aclk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      rh = 1'b0;
      while (!rh)
      begin
         @(negedge aclk);
         ah = arvalid & arready;
         rh = rvalid;
         d  = rdata;
         r  = rresp;
         @(posedge aclk);
         if (ah)
            arvalid <= 1'b0;
         if (rh)
            rready <= 1'b0;
      end
   endtask

   task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
      rdr(a, rd, rsp);
      chk(nm, rd, exp);
      chk("rresp", {30'h0, rsp}, {30'h0, RESP_OKAY});
   endtask

   task automatic mis(input cos_mis_cmd_t c, input logic [4:0] o);
      @(posedge aclk);
      mis_req <= '{1'b1, c, o};
      @(posedge aclk);
      mis_req <= '0;
      cyc(3);
   endtask

   task automatic evt(input logic rx, input logic tx, input logic [4:0] o);
      @(posedge aclk);
      mh_evt <= '{rx, tx, o};
      @(posedge aclk);
      mh_evt <= '0;
      cyc(3);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (30000) @(posedge aclk);
      err_total++;
      end_sim();
   end

   initial
   begin
      aresetn = 1'b0;
      {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
      mis_req = '0;
      mh_evt = '0;
      err_total = 0;
      checks_done = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rchk("nd_high", ADDR_NEW_DATA_HIGH, 32'h0);
      rchk("ip_low", ADDR_INT_PENDING_LOW, 32'h0);
      rchk("ip_high", ADDR_INT_PENDING_HIGH, 32'h0);
      rchk("ov_low", ADDR_OBJ_VALID_LOW, 32'h0);
      rchk("ov_high", ADDR_OBJ_VALID_HIGH, 32'h0);
      rchk("clkdiv", ADDR_CORE_CLOCK_DIV, 32'h0);
      rchk("irq_mask", ADDR_IRQ_MASK, 32'h0);
      rchk("pend_id", ADDR_PENDING_ID, 32'h0);
      // Event on an object that is not valid
      evt(1'b1, 1'b0, 5'd19);
      chk("nd_port", nd_flags, 32'h0);
      chk("ip_port", ip_flags, 32'h0);
      mis(MIS_SET_OV, 5'd19);
      mis(MIS_SET_OV, 5'd2);
      rchk("ov_low", ADDR_OBJ_VALID_LOW, 32'h4);
      rchk("ov_high", ADDR_OBJ_VALID_HIGH, 32'h8);
      evt(1'b1, 1'b0, 5'd19);
      rchk("nd_high", ADDR_NEW_DATA_HIGH, 32'h8);
      rchk("ip_high", ADDR_INT_PENDING_HIGH, 32'h8);
      chk("pid_port", {26'h0, pending_id}, 32'd20);
      evt(1'b0, 1'b1, 5'd2);
      chk("nd_port", nd_flags, 32'h0008_0004);
      chk("ip_port", ip_flags, 32'h0008_0004);
      rchk("ip_low", ADDR_INT_PENDING_LOW, 32'h4);
      rchk("pend_id", ADDR_PENDING_ID, 32'd3);
      chk("ov_port", ov_flags, 32'h0008_0004);
      rchk("irq_stat", ADDR_IRQ_STATUS, 32'h3);
      chk("irq_masked", {31'h0, irq}, 32'h0);
      wr(ADDR_IRQ_MASK, 32'h1, rsp);
      cyc(3);
      chk("irq_on", {31'h0, irq}, 32'h1);
      wr(ADDR_IRQ_STATUS, 32'h1, rsp);
      cyc(3);
      chk("irq_off", {31'h0, irq}, 32'h0);
      rchk("irq_stat", ADDR_IRQ_STATUS, 32'h2);
      mis(MIS_CLR_ND, 5'd19);
      rchk("nd_high", ADDR_NEW_DATA_HIGH, 32'h0);
      mis(MIS_SET_ND, 5'd31);
      rchk("nd_high", ADDR_NEW_DATA_HIGH, 32'h8000);
      mis(MIS_CLR_IP, 5'd2);
      rchk("ip_low", ADDR_INT_PENDING_LOW, 32'h0);
      rchk("pend_id", ADDR_PENDING_ID, 32'd20);
      mis(MIS_SET_IP, 5'd16);
      rchk("ip_high", ADDR_INT_PENDING_HIGH, 32'h9);
      rchk("irq_stat_sw", ADDR_IRQ_STATUS, 32'h6);
      mis(MIS_CLR_OV, 5'd19);
      rchk("ov_high", ADDR_OBJ_VALID_HIGH, 32'h0);
      // Writes to status registers leave them as they were
      wr(ADDR_NEW_DATA_HIGH, 32'hffff_ffff, rsp);
      chk("bresp_ro", {30'h0, rsp}, {30'h0, RESP_OKAY});
      wr(ADDR_OBJ_VALID_LOW, 32'h0, rsp);
      chk("bresp_ro", {30'h0, rsp}, {30'h0, RESP_OKAY});
      rchk("nd_high", ADDR_NEW_DATA_HIGH, 32'h8000);
      rchk("ov_low", ADDR_OBJ_VALID_LOW, 32'h4);
      wr(32'h4005_0200, 32'h1, rsp);
      chk("bresp_bad", {30'h0, rsp}, {30'h0, RESP_SLVERR});
      rdr(32'h4005_0200, rd, rsp);
      chk("rresp_bad", {30'h0, rsp}, {30'h0, RESP_SLVERR});
      // Enable pulses counted over 48 cycles, a multiple of each period
      foreach (divs[i])
      begin
         wr(ADDR_CORE_CLOCK_DIV, {28'h0, divs[i]}, rsp);
         rchk("clkdiv", ADDR_CORE_CLOCK_DIV, {28'h0, divs[i]});
         cyc(20);
         cnt = 0;
         repeat (48)
         begin
            @(negedge aclk);
            cnt += int'(can_clk_en === 1'b1);
         end
         chk("clk_pulses", cnt, 48 / (divs[i] + 1));
      end
      end_sim();
   end
endmodule

// ==== src/cos_pkg.sv ====
package cos_pkg;

   localparam int          NUM_OBJ        = 32;
   localparam int          HALF_OBJ       = 16;
   localparam int          ADDR_W         = 32;
   localparam int          DATA_W         = 32;
   localparam int          DIV_W          = 4;
   localparam int          OBJ_IDX_W      = 5;

   // Register byte addresses
   localparam logic [31:0] ADDR_NEW_DATA_HIGH     = 32'h40050124;
   localparam logic [31:0] ADDR_INT_PENDING_LOW   = 32'h40050140;
   localparam logic [31:0] ADDR_INT_PENDING_HIGH  = 32'h40050144;
   localparam logic [31:0] ADDR_OBJ_VALID_LOW     = 32'h40050160;
   localparam logic [31:0] ADDR_OBJ_VALID_HIGH    = 32'h40050164;
   localparam logic [31:0] ADDR_CORE_CLOCK_DIV    = 32'h40050180;
   localparam logic [31:0] ADDR_IRQ_STATUS        = 32'h40050190;
   localparam logic [31:0] ADDR_IRQ_MASK          = 32'h40050194;
   localparam logic [31:0] ADDR_PENDING_ID        = 32'h40050198;

   // Field layout and reset values
   localparam int          FLAG_LSB       = 0;
   localparam int          FLAG_MSB       = 15;
   localparam int          DIV_LSB        = 0;
   localparam int          DIV_MSB        = 3;
   localparam logic [15:0] FLAG_RESET     = 16'h0000;
   localparam logic [3:0]  DIV_RESET      = 4'h0;
   localparam logic [2:0]  IRQ_RESET      = 3'h0;
   localparam logic [5:0]  ID_NONE        = 6'h00;

   // Interrupt status bit positions
   localparam int          IRQ_RX_BIT     = 0;
   localparam int          IRQ_TX_BIT     = 1;
   localparam int          IRQ_SW_BIT     = 2;
   localparam int          IRQ_W          = 3;

   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;

   typedef enum logic [3:0]
   {
      MIS_NONE   = 4'h0,
      MIS_SET_ND = 4'h1,
      MIS_CLR_ND = 4'h2,
      MIS_SET_IP = 4'h3,
      MIS_CLR_IP = 4'h4,
      MIS_SET_OV = 4'h5,
      MIS_CLR_OV = 4'h6
   } cos_mis_cmd_t;

   // Message interface set command
   typedef struct packed
   {
      logic                 valid;
      cos_mis_cmd_t         cmd;
      logic [OBJ_IDX_W-1:0] obj;
   } cos_mis_req_t;

   // Message handler event
   typedef struct packed
   {
      logic                 rx_data;
      logic                 tx_done;
      logic [OBJ_IDX_W-1:0] obj;
   } cos_mh_evt_t;

   typedef enum logic [1:0]
   {
      RD_IDLE = 2'b01,
      RD_RESP = 2'b10
   } cos_rd_state_t;

endpackage

// ==== src/cos_status_regs.sv ====
`timescale 1ns/1ns
// Functional notes
// RULE1: New-data flags of objects 17..32 appear in bits 15:0, ascending order.
// RULE2: New-data flag set/cleared by interface set; handler sets on rx or tx done.
// RULE3: New-data 0 means nothing written since cleared; 1 means new data written.
// RULE4: Interrupt-pending flags 1..16 and 17..32 in bits 15:0 of two registers.
// RULE5: Handler sets pending flag on rx or tx; interface set sets or clears.
// RULE6: Pending flag changes are mirrored in the pending-interrupt identifier.
// RULE7: Object-valid flags 1..16 and 17..32 in bits 15:0 of two read-only registers.
// RULE8: Only the interface set changes an object-valid flag.
// RULE9: Handler events for objects whose valid flag is 0 are ignored.
// RULE10: Core clock enable rate is clock divided by divisor plus one.
// RULE11: Divisor is read/write and resets to zero, giving undivided clock.
// RULE12: All object status registers reset to zero; bits 31:16 read zero.
// RULE13: Handler status registers are read-only to the processor.
// RULE14: Writes to read-only status registers are ignored with an OKAY response.
module cos_status_regs
   import cos_pkg::*;
(
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   input  wire logic [DATA_W-1:0]    s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   input  wire logic [ADDR_W-1:0]    s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   output logic [DATA_W-1:0]         s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   input  wire cos_mis_req_t         mis_req,
   input  wire cos_mh_evt_t          mh_evt,
   output logic [NUM_OBJ-1:0]        new_data_flag,
   output logic [NUM_OBJ-1:0]        interrupt_pending_flag,
   output logic [NUM_OBJ-1:0]        object_valid_flag,
   output logic [5:0]                pending_id,
   output logic                      can_clk_en,
   output logic                      irq
);

   ////////////////////////////////////////////////////////////////////////
   // Object flags

   logic [NUM_OBJ-1:0] nd_reg;
   logic [NUM_OBJ-1:0] ip_reg;
   logic [NUM_OBJ-1:0] ov_reg;
   logic [5:0]         id_reg;
   logic [5:0]         id_next;
   logic               evt_ok;

   assign evt_ok = ov_reg[mh_evt.obj] & (mh_evt.rx_data | mh_evt.tx_done);  // [RULE9]

   genvar g;
   generate
      for (g = 0; g < NUM_OBJ; g++)
      begin : g_obj
         logic mis_hit;
         logic evt_hit;
         assign mis_hit = mis_req.valid && (mis_req.obj == OBJ_IDX_W'(g));
         assign evt_hit = evt_ok && (mh_evt.obj == OBJ_IDX_W'(g));

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               nd_reg[g] <= 1'b0;  // [RULE12]
            else if (evt_hit)
               nd_reg[g] <= 1'b1;  // [RULE2] [RULE3]
            else if (mis_hit && mis_req.cmd == MIS_SET_ND)
               nd_reg[g] <= 1'b1;  // [RULE2]
            else if (mis_hit && mis_req.cmd == MIS_CLR_ND)
               nd_reg[g] <= 1'b0;  // [RULE3]
         end

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               ip_reg[g] <= 1'b0;  // [RULE12]
            else if (evt_hit)
               ip_reg[g] <= 1'b1;  // [RULE5]
            else if (mis_hit && mis_req.cmd == MIS_SET_IP)
               ip_reg[g] <= 1'b1;  // [RULE5]
            else if (mis_hit && mis_req.cmd == MIS_CLR_IP)
               ip_reg[g] <= 1'b0;  // [RULE5]
         end

         always_ff @(posedge aclk)
         begin
            if (!aresetn)
               ov_reg[g] <= 1'b0;  // [RULE12]
            else if (mis_hit && mis_req.cmd == MIS_SET_OV)
               ov_reg[g] <= 1'b1;  // [RULE8]
            else if (mis_hit && mis_req.cmd == MIS_CLR_OV)
               ov_reg[g] <= 1'b0;  // [RULE8]
         end
      end
   endgenerate

   // Lowest pending object number, 0 when none
   always_comb
   begin
      id_next = ID_NONE;
      for (int i = NUM_OBJ - 1; i >= 0; i--)
         if (ip_reg[i])
            id_next = 6'(i + 1);  // [RULE6]
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         id_reg <= ID_NONE;
      else
         id_reg <= id_next;  // [RULE6]
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         new_data_flag          <= '0;
         interrupt_pending_flag <= '0;
         object_valid_flag      <= '0;
         pending_id             <= ID_NONE;
      end
      else
      begin
         new_data_flag          <= nd_reg;
         interrupt_pending_flag <= ip_reg;
         object_valid_flag      <= ov_reg;
         pending_id             <= id_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Core clock divider

   logic [DIV_W-1:0] div_reg;
   logic [DIV_W-1:0] cnt_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         cnt_reg    <= '0;
         can_clk_en <= 1'b0;
      end
      else if (cnt_reg >= div_reg)
      begin
         cnt_reg    <= '0;
         can_clk_en <= 1'b1;  // [RULE10]
      end
      else
      begin
         cnt_reg    <= cnt_reg + 4'h1;
         can_clk_en <= 1'b0;  // [RULE10]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Interrupt status and mask

   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_mask_reg;
   logic [IRQ_W-1:0] irq_set;
   logic             sw_ip_change;

   assign sw_ip_change = mis_req.valid && (mis_req.cmd == MIS_SET_IP || mis_req.cmd == MIS_CLR_IP);
   assign irq_set      = {sw_ip_change, evt_ok & mh_evt.tx_done, evt_ok & mh_evt.rx_data};

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path

   logic [ADDR_W-1:0] aw_addr_reg;
   logic              aw_have_reg;
   logic [DATA_W-1:0] w_data_reg;
   logic [3:0]        w_strb_reg;
   logic              w_have_reg;
   logic              wr_do;

   assign wr_do = aw_have_reg && w_have_reg && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      s_axi_awready <= aresetn && !aw_have_reg && !(s_axi_awvalid && s_axi_awready)
                       && !(s_axi_bvalid && !s_axi_bready);
      s_axi_wready  <= aresetn && !w_have_reg && !(s_axi_wvalid && s_axi_wready)
                       && !(s_axi_bvalid && !s_axi_bready);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_reg <= 1'b0;
         aw_addr_reg <= '0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_reg <= 1'b1;
         aw_addr_reg <= s_axi_awaddr;
      end
      else if (wr_do)
         aw_have_reg <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_have_reg <= 1'b0;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_reg <= 1'b1;
         w_data_reg <= s_axi_wdata;
         w_strb_reg <= s_axi_wstrb;
      end
      else if (wr_do)
         w_have_reg <= 1'b0;
   end

   logic wr_known;

   always_comb
   begin
      case (aw_addr_reg)
         ADDR_NEW_DATA_HIGH, ADDR_INT_PENDING_LOW, ADDR_INT_PENDING_HIGH,
         ADDR_OBJ_VALID_LOW, ADDR_OBJ_VALID_HIGH, ADDR_PENDING_ID,
         ADDR_CORE_CLOCK_DIV, ADDR_IRQ_STATUS, ADDR_IRQ_MASK:
            wr_known = 1'b1;  // [RULE13] [RULE14]
         default:
            wr_known = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         div_reg <= DIV_RESET;  // [RULE11]
      else if (wr_do && aw_addr_reg == ADDR_CORE_CLOCK_DIV && w_strb_reg[0])
         div_reg <= w_data_reg[DIV_MSB:DIV_LSB];  // [RULE11]
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_mask_reg <= IRQ_RESET;
      else if (wr_do && aw_addr_reg == ADDR_IRQ_MASK && w_strb_reg[0])
         irq_mask_reg <= w_data_reg[IRQ_W-1:0];
   end

   // Set wins over write-one-to-clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_stat_reg <= IRQ_RESET;
      else if (wr_do && aw_addr_reg == ADDR_IRQ_STATUS && w_strb_reg[0])
         irq_stat_reg <= (irq_stat_reg & ~w_data_reg[IRQ_W-1:0]) | irq_set;
      else
         irq_stat_reg <= irq_stat_reg | irq_set;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq <= 1'b0;
      else
         irq <= |(irq_stat_reg & irq_mask_reg);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (wr_do)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;  // [RULE14]
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path

   cos_rd_state_t     rd_state;
   logic [DATA_W-1:0] rd_data;
   logic              rd_known;

   always_comb
   begin
      rd_data  = '0;  // [RULE12]
      rd_known = 1'b1;
      case (s_axi_araddr)
         ADDR_NEW_DATA_HIGH:    rd_data[FLAG_MSB:FLAG_LSB] = nd_reg[NUM_OBJ-1:HALF_OBJ];  // [RULE1]
         ADDR_INT_PENDING_LOW:  rd_data[FLAG_MSB:FLAG_LSB] = ip_reg[HALF_OBJ-1:0];  // [RULE4]
         ADDR_INT_PENDING_HIGH: rd_data[FLAG_MSB:FLAG_LSB] = ip_reg[NUM_OBJ-1:HALF_OBJ];  // [RULE4]
         ADDR_OBJ_VALID_LOW:    rd_data[FLAG_MSB:FLAG_LSB] = ov_reg[HALF_OBJ-1:0];  // [RULE7]
         ADDR_OBJ_VALID_HIGH:   rd_data[FLAG_MSB:FLAG_LSB] = ov_reg[NUM_OBJ-1:HALF_OBJ];  // [RULE7]
         ADDR_CORE_CLOCK_DIV:   rd_data[DIV_MSB:DIV_LSB] = div_reg;
         ADDR_IRQ_STATUS:       rd_data[IRQ_W-1:0] = irq_stat_reg;
         ADDR_IRQ_MASK:         rd_data[IRQ_W-1:0] = irq_mask_reg;
         ADDR_PENDING_ID:       rd_data[5:0] = id_reg;  // [RULE6]
         default:               rd_known = 1'b0;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_state     <= RD_IDLE;
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end
      else
      begin
         case (rd_state)
            RD_IDLE:
               if (s_axi_arvalid && s_axi_arready)
               begin
                  rd_state     <= RD_RESP;
                  s_axi_arready <= 1'b0;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rdata  <= rd_data;
                  s_axi_rresp  <= rd_known ? RESP_OKAY : RESP_SLVERR;
               end
            RD_RESP:
               if (s_axi_rready)
               begin
                  rd_state     <= RD_IDLE;
                  s_axi_arready <= 1'b1;
                  s_axi_rvalid <= 1'b0;
               end
            default:
               rd_state <= RD_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks

   sequence s_valid_evt;
      evt_ok && !mis_req.valid;
   endsequence

   a_event_sets_flags: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE5]
      s_valid_evt |=> ip_reg[$past(mh_evt.obj)] && nd_reg[$past(mh_evt.obj)])
      else $error("handler event did not set flags");

   a_invalid_ignored: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE9]
      (!mis_req.valid && !ov_reg[mh_evt.obj]) |=> $stable(ip_reg) && $stable(nd_reg))
      else $error("event on invalid object changed flags");

   a_valid_only_sw: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE8]
      !mis_req.valid |=> $stable(ov_reg))
      else $error("valid flag changed without interface set");

   a_ro_write_kept: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE14]
      (wr_do && aw_addr_reg == ADDR_OBJ_VALID_LOW && !mis_req.valid)
      |=> $stable(ov_reg) && s_axi_bresp == RESP_OKAY)
      else $error("write to read-only register had effect");

   a_div_period: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE10]
      (can_clk_en && div_reg == 4'h1 && $stable(div_reg)) ##1 (div_reg == 4'h1) |-> !can_clk_en ##1 can_clk_en)
      else $error("divide by two period wrong");

   a_undivided: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE11]
      (div_reg == DIV_RESET)[*2] |=> can_clk_en)
      else $error("undivided clock enable missing");

   a_id_tracks: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE6]
      (ip_reg == '0)[*2] |=> pending_id == ID_NONE)
      else $error("pending id wrong");

   a_read_reserved: assert property (@(posedge aclk) disable iff (!aresetn)  // [RULE12]
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_NEW_DATA_HIGH)
      |=> s_axi_rvalid && s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[15:0] == $past(nd_reg[31:16]))
      else $error("new data read wrong");

endmodule
